// ---- hdl/ssr_buf2.sv ----
`timescale 1ns/10ps
module ssr_buf2 #(
  parameter int W = 12
) (
  input  wire logic         clock_i,
  input  wire logic         nrst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  wire          push = in_valid_i && in_ready_o;
  wire          pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o  = mem_r[rp_r];
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data_i;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- hdl/ssr_dev.sv ----
`timescale 1ns/10ps
module ssr_dev #(
  parameter int BITS = ssr_pkg::DEF_BITS
) (
  // System
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  // Link
  ssr_if.dev                     lnk,
  // Analog sample stand-in
  input  wire logic [BITS-1:0]   sample_i,
  // Status
  output logic                   awake_o,
  output logic                   holding_o
);
  localparam int EOC = ssr_pkg::eoc_edge(BITS);
  logic [1:0]       sel_s_r;
  logic [1:0]       sck_s_r;
  logic             sck_d_r;
  logic             sel_d_r;
  logic [4:0]       fall_r;
  logic [BITS-1:0]  shf_r;
  logic             sdo_r;
  logic             oe_r;
  wire sel_n   = sel_s_r[1];
  wire sck_f   = sck_d_r && !sck_s_r[1];
  wire sel_f   = sel_d_r && !sel_n;
  wire sel_r   = !sel_d_r && sel_n;
  wire at_end  = sck_f && awake_o && (fall_r == 5'(EOC - 1));
  assign lnk.sdo_o  = sdo_r;
  assign lnk.sdo_oe = oe_r;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_s_r   <= 2'h3;
      sck_s_r   <= 2'h3;
      sck_d_r   <= 1'b1;
      sel_d_r   <= 1'b1;
      fall_r    <= 5'h00;
      shf_r     <= '0;
      sdo_r     <= 1'b0;
      oe_r      <= 1'b0;
      awake_o   <= 1'b0;
      holding_o <= 1'b0;
    end else begin
      sel_s_r <= {sel_s_r[0], lnk.sel_n};
      sck_s_r <= {sck_s_r[0], lnk.sck};
      sck_d_r <= sck_s_r[1];
      sel_d_r <= sel_n;
      if (sel_r || at_end) begin
        oe_r      <= 1'b0;
        awake_o   <= 1'b0;
        holding_o <= 1'b0;
        fall_r    <= 5'h00;
      end else if (sel_f) begin
        oe_r    <= 1'b1;
        sdo_r   <= 1'b0;
        awake_o <= 1'b1;
        fall_r  <= 5'h00;
      end else if (sck_f && awake_o) begin
        fall_r <= fall_r + 5'h01;
        if (fall_r == 5'(ssr_pkg::HOLD_EDGE - 1)) begin
          holding_o <= 1'b1;
          shf_r     <= sample_i;
          sdo_r     <= 1'b0;
        end else if (fall_r < 5'(ssr_pkg::HOLD_EDGE - 1)) begin
          sdo_r <= 1'b0;
        end else begin
          sdo_r <= shf_r[BITS-1];
          shf_r <= {shf_r[BITS-2:0], 1'b0};
        end
      end
    end
  end
endmodule

// ---- hdl/ssr_host.sv ----
`timescale 1ns/10ps
module ssr_host #(
  parameter int BITS = ssr_pkg::DEF_BITS
) (
  // System
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  // Link
  ssr_if.host                    lnk,
  // User request
  input  wire logic              start_i,
  output logic                   busy_o,
  // Result stream
  output logic                   res_valid_o,
  input  wire logic              res_ready_i,
  output logic [BITS-1:0]        res_data_o
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_RUN  = 2'b10,
    ST_GAP  = 2'b11
  } ssr_st_type;
  localparam int TOTAL = ssr_pkg::eoc_edge(BITS);
  ssr_st_type      st_r;
  logic            sel_r;
  logic            sck_r;
  logic [7:0]      tmr_r;
  logic [4:0]      edg_r;
  logic [1:0]      din_s_r;
  logic [BITS-1:0] cap_r;
  logic            push_r;
  logic            init_r;
  logic            buf_rdy;
  wire             sdo_in = din_s_r[1];
  wire             tick   = (tmr_r == 8'h00);
  assign lnk.sel_n = sel_r;
  assign lnk.sck   = sck_r;
  assign busy_o    = (st_r != ST_IDLE);
  // Stalls next frame when buffer is full, so no word is lost
  wire go = start_i && buf_rdy;
  ssr_buf2 #(.W(BITS)) u_buf (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (push_r),
    .in_ready_o  (buf_rdy),
    .in_data_i   (cap_r),
    .out_valid_o (res_valid_o),
    .out_ready_i (res_ready_i),
    .out_data_o  (res_data_o)
  );
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r    <= ST_IDLE;
      sel_r   <= 1'b1;
      sck_r   <= 1'b1;
      tmr_r   <= 8'h00;
      edg_r   <= 5'h00;
      din_s_r <= 2'h0;
      cap_r   <= '0;
      push_r  <= 1'b0;
      init_r  <= 1'b1;
    end else begin
      din_s_r <= {din_s_r[0], lnk.sdo_line};
      push_r  <= 1'b0;
      if (!tick)
        tmr_r <= tmr_r - 8'h01;
      case (st_r)
        ST_IDLE: begin
          sck_r <= 1'b1;
          if (init_r || go) begin
            sel_r <= 1'b0;
            edg_r <= 5'h00;
            tmr_r <= 8'(ssr_pkg::ACQ_CYC);
            st_r  <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (init_r) begin
            sel_r  <= 1'b1;
            init_r <= 1'b0;
            tmr_r  <= 8'(ssr_pkg::GAP_CYC);
            st_r   <= ST_GAP;
          end else if (tick) begin
            sck_r <= 1'b0;
            tmr_r <= 8'(ssr_pkg::SCK_HALF_CYC);
            edg_r <= 5'h01;
            st_r  <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick) begin
            tmr_r <= 8'(ssr_pkg::SCK_HALF_CYC);
            if (!sck_r) begin
              sck_r <= 1'b1;
              // Sync lag: a rise sees the bit of the fall before it,
              // so the last lead zero falls off past the top bit
              if (edg_r > 5'(ssr_pkg::LEAD_ZEROS - 1))
                cap_r <= {cap_r[BITS-2:0], sdo_in};
              if (edg_r == 5'(TOTAL)) begin
                push_r <= 1'b1;
                sel_r  <= 1'b1;
                tmr_r  <= 8'(ssr_pkg::GAP_CYC);
                st_r   <= ST_GAP;
              end
            end else begin
              sck_r <= 1'b0;
              edg_r <= edg_r + 5'h01;
            end
          end
        end
        ST_GAP: begin
          if (tick)
            st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// ---- hdl/ssr_if.sv ----
`timescale 1ns/10ps
interface ssr_if;
  logic sel_n;
  logic sck;
  logic sdo_o;
  logic sdo_oe;
  wire  sdo_line = sdo_oe ? sdo_o : 1'b1;
  modport dev (input sel_n, input sck, output sdo_o, output sdo_oe);
  modport host (output sel_n, output sck, input sdo_line);
endinterface

// ---- hdl/ssr_pkg.sv ----
// Operation
// - Host lowers select, then clocks the frame
// - Track until third falling edge, then hold
// - Select to third fall meets acquisition time
// - Conversion lasts 13, 11 or 9 periods
// - Acquisition equals setup plus two periods
// - Host serial clock within supply limit
// - Host frame period per cycle formula
// - Host idles serial clock high
// - Change on falling edge, sample on rising
// - Output driven from select fall, zero first
// - Zero held, three zeros on falls 1-3
// - MSB presented on fourth falling edge
// - Result MSB first, straight binary
// - Release output on select rise or end
// - End at fall 16, 14 or 12
// - Early select rise aborts, powers down
// - Wake on select fall, sleep at end
// - Host pulses select once after power-on
package ssr_pkg;
  localparam int    CLK_HZ          = 20000000;
  localparam int    LEAD_ZEROS      = 4;
  localparam int    HOLD_EDGE       = 3;
  localparam int    SETUP_NS        = 643;
  localparam int    CLK_NS          = 50;
  localparam int    ACQ_CYC         = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int    SCK_HALF_CYC    = 3;
  localparam int    GAP_NS          = 100;
  localparam int    GAP_CYC         = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int    DEF_BITS        = 12;
  function automatic int conv_periods(input int bits);
    return bits + 1;
  endfunction
  function automatic int eoc_edge(input int bits);
    return bits + LEAD_ZEROS;
  endfunction
endpackage

// ---- testbench/ssr_chk_asserts.sv ----
`timescale 1ns/10ps
module ssr_chk #(
  parameter int BITS = 12
) (
  // System
  input wire logic clock_i,
  input wire logic nrst_i,
  // Link
  input wire logic sel_n,
  input wire logic sck,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  localparam int EOC = BITS + 4;
  logic       sck_r;
  logic [4:0] fall_r;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // ----
  // Falls in frame
  // ----
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_r  <= 1'b1;
      fall_r <= 5'h0;
    end else begin
      sck_r  <= sck;
      fall_r <= sel_n ? 5'h0 : fall_r + {4'h0, sck_r & ~sck};
    end
  end
  idle_high_a: assert property (sel_n |-> sck)
    else $error("sck low while idle");
  edge_framed_a: assert property ($fell(sck) |-> !sel_n)
    else $error("sck edge outside frame");
  setup_wait_a: assert property ($fell(sel_n) |-> sck[*8])
    else $error("first fall too soon");
  half_width_a: assert property ($fell(sck) |-> (!sck)[*3])
    else $error("sck low phase short");
  lead_drive_a: assert property ($fell(sel_n) ##0 (!sel_n)[*5]
    |-> sdo_oe && !sdo_o) else $error("no lead zero");
  stable_high_a: assert property (sck && $past(sck) && sdo_oe
    && $past(sdo_oe) && fall_r != 5'h0 |-> $stable(sdo_o))
    else $error("sdo moved while sck high");
  lead_zero_a: assert property ($rose(sck) && fall_r < 4
    && fall_r != 5'h0 |-> !sdo_o) else $error("lead bit not zero");
  eoc_release_a: assert property ($rose(fall_r == EOC)
    |-> ##[0:4] !sdo_oe) else $error("no release at end");
  frame_drive_a: assert property (!sel_n && fall_r != 5'h0
    && fall_r < EOC |-> sdo_oe) else $error("early release");
  fall_count_a: assert property ($rose(sel_n)
    |-> fall_r == 5'h0 || fall_r == EOC) else $error("bad fall count");
  cover property ($rose(sel_n) && fall_r == EOC);
  cover property ($rose(sel_n) && fall_r == 5'h0);
  cover property ($rose(sck) && sdo_o);
endmodule

// ---- testbench/test_sar_adc_serial_readout.sv ----
`timescale 1ns/10ps
module test_sar_adc_serial_readout;
  localparam int BITS = ssr_pkg::DEF_BITS;
  logic            clock_i;
  logic            nrst_i;
  logic            start_r;
  logic            ready_r;
  logic            vld;
  logic            busy;
  logic            awake2;
  logic            hold2;
  logic            sck_q;
  logic [15:0]     lfsr_r;
  logic [BITS-1:0] sample_r;
  logic [BITS-1:0] sample2_r;
  logic [BITS-1:0] data;
  logic [BITS-1:0] exp_q[$];
  int              fcnt;
  int              bad_count;
  int              checked;
  ssr_if lnk();
  ssr_if lnk2();
  ssr_host #(.BITS(BITS)) u_ssr_host (.clock_i(clock_i), .nrst_i(nrst_i),
    .lnk(lnk.host), .start_i(start_r), .busy_o(busy), .res_valid_o(vld),
    .res_ready_i(ready_r), .res_data_o(data));
  ssr_dev #(.BITS(BITS)) u_ssr_dev (.clock_i(clock_i), .nrst_i(nrst_i),
    .lnk(lnk.dev), .sample_i(sample_r), .awake_o(), .holding_o());
  // Bench drives this one directly, to break the frame on purpose
  ssr_dev #(.BITS(BITS)) u_ssr_dev_2 (.clock_i(clock_i), .nrst_i(nrst_i),
    .lnk(lnk2.dev), .sample_i(sample2_r), .awake_o(awake2),
    .holding_o(hold2));
  ssr_chk #(.BITS(BITS)) u_ssr_chk (.clock_i(clock_i), .nrst_i(nrst_i),
    .sel_n(lnk.sel_n), .sck(lnk.sck), .sdo_o(lnk.sdo_o),
    .sdo_oe(lnk.sdo_oe));
  // ----
  // Helpers
  // ----
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic exp_bit(input logic [BITS-1:0] w, input int k);
    return (k < 4) ? 1'b0 : w[BITS+3-k];
  endfunction
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic frame2(input int nf, input logic [BITS-1:0] w);
    sample2_r <= w;
    lnk2.sel_n <= 1'b0;
    repeat (16) @(posedge clock_i);
    chk(lnk2.sdo_line === 1'b0, "first zero");
    for (int k = 1; k <= nf; k++) begin
      lnk2.sck <= 1'b0;
      repeat (4) @(posedge clock_i);
      if (k < BITS + 4) chk(lnk2.sdo_line === exp_bit(w, k), "bit");
      if (k == 2) chk(hold2 === 1'b0 && awake2 === 1'b1, "track");
      if (k == 3) chk(hold2 === 1'b1, "hold");
      if (k == BITS + 3) chk(lnk2.sdo_oe === 1'b1, "late drive");
      lnk2.sck <= 1'b1;
      repeat (4) @(posedge clock_i);
    end
    chk(lnk2.sdo_oe === (nf < BITS + 4), "end drive");
    lnk2.sel_n <= 1'b1;
    repeat (6) @(posedge clock_i);
    chk(!lnk2.sdo_oe && !awake2 && lnk2.sdo_line, "sleep");
  endtask
  // ----
  // Sampling and result check
  // ----
  always @(posedge clock_i) begin
    lfsr_r <= lfsr_next(lfsr_r);
    sck_q <= lnk.sck;
    if (lnk.sel_n) sample_r <= lfsr_r[BITS-1:0];
    if (lnk.sel_n) fcnt = 0;
    else if (sck_q && !lnk.sck) begin
      fcnt++;
      if (fcnt == 3) exp_q.push_back(sample_r);
    end
    if (vld === 1'b1 && ready_r === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "extra word");
      else chk(data === exp_q.pop_front(), "word");
    end
  end
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    nrst_i = 1'b0;
    start_r = 1'b0;
    ready_r = 1'b0;
    sample2_r = '0;
    lfsr_r = 16'hE3EC;
    sck_q = 1'b1;
    fcnt = 0;
    lnk2.sel_n = 1'b1;
    lnk2.sck = 1'b1;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (40) @(posedge clock_i);
    frame2(BITS + 4, '1);
    frame2(6, lfsr_r[BITS-1:0]);
    frame2(BITS + 4, BITS'(1));
    start_r <= 1'b1;
    repeat (700) @(posedge clock_i);
    chk(exp_q.size() == 2 && vld === 1'b1, "full stall");
    chk(busy === 1'b0, "stall idle");
    repeat (2500) begin
      @(posedge clock_i);
      ready_r <= lfsr_r[3];
    end
    @(posedge clock_i);
    start_r <= 1'b0;
    ready_r <= 1'b1;
    repeat (400) @(posedge clock_i);
    chk(exp_q.size() == 0, "drained");
    tally_and_finish;
  end
endmodule
